// *** hdl/irg_host_ctrl.sv ***
`timescale 1ns/100ps
`include "irg_map.svh"

module irg_host_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link to sensor
    irg_link_if.host_mp link,
    // Software register port
    input wire irg_pkg::irg_byte_t sw_addr,
    input wire irg_pkg::irg_byte_t sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output irg_pkg::irg_byte_t sw_rdata,
    // Interrupt
    output logic irq
);
    import irg_pkg::*;

    irg_host_state_s st_q;
    irg_host_state_s st_d;

    // Guard outgoing writes to the interrupt control register
    function automatic irg_byte_t guard_wr(input irg_byte_t addr, input irg_byte_t data,
                                           input logic no_flags);
        irg_byte_t res;
        res = data;
        if (addr == `IRG_OFF_INT_CTRL && data[`IRG_IC_SRC_MSB:`IRG_IC_SRC_LSB] == `IRG_SRC_OR)
        begin
            res[`IRG_IC_LATCH] = 1'b0;
            // Flags are meaningless in one-shot or wide mode
            if (no_flags)
            begin
                res[`IRG_IC_SRC_MSB:`IRG_IC_SRC_LSB] = `IRG_SRC_NONE;
            end
        end
        return res;
    endfunction : guard_wr

    always_comb
    begin
        irg_byte_t wa;
        irg_byte_t wd;
        logic issue;
        wa = st_q.dev_addr;
        wd = st_q.dev_wdata;
        issue = 1'b0;
        st_d = st_q;
        st_d.reg_wr = 1'b0;
        st_d.reg_rd = 1'b0;
        st_d.sw_rdata = 8'h00;
        st_d.rd_pend = st_q.reg_rd;
        st_d.pin_s1 = link.int_pin;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_prev = st_q.pin_s2;

        if (sw_wr)
        begin
            unique case (sw_addr)
                `IRG_H_DEV_ADDR:
                begin
                    st_d.dev_addr = sw_wdata;
                end
                `IRG_H_DEV_WDATA:
                begin
                    st_d.dev_wdata = sw_wdata;
                end
                `IRG_H_CMD:
                begin
                    if (sw_wdata[`IRG_CMD_PRESET])
                    begin
                        wa = `IRG_OFF_INT_CTRL;
                        wd = `IRG_PRESET_PRESENCE;
                        issue = 1'b1;
                    end
                    else if (sw_wdata[`IRG_CMD_WR])
                    begin
                        issue = 1'b1;
                    end
                    else if (sw_wdata[`IRG_CMD_RD])
                    begin
                        st_d.reg_addr = st_q.dev_addr;
                        st_d.reg_rd = 1'b1;
                    end
                end
                `IRG_H_IRQ_STATUS:
                begin
                    st_d.irq_status = st_q.irq_status & ~sw_wdata[2:0];
                end
                `IRG_H_IRQ_MASK:
                begin
                    st_d.irq_mask = sw_wdata[2:0];
                end
                `IRG_H_CFG:
                begin
                    st_d.one_shot = sw_wdata[`IRG_CFG_ONE_SHOT];
                end
                default:
                begin
                end
            endcase
        end

        if (issue)
        begin
            st_d.reg_addr = wa;
            st_d.reg_wdata = guard_wr(wa, wd, st_q.one_shot | st_q.wide_seen);
            st_d.reg_wr = 1'b1;
            if (wa == `IRG_OFF_GAIN_CONFIG)
            begin
                st_d.wide_seen = wd[`IRG_GAIN_MSB:`IRG_GAIN_LSB] == `IRG_GAIN_WIDE;
            end
        end

        if (sw_rd)
        begin
            unique case (sw_addr)
                `IRG_H_DEV_ADDR: st_d.sw_rdata = st_q.dev_addr;
                `IRG_H_DEV_WDATA: st_d.sw_rdata = st_q.dev_wdata;
                `IRG_H_DEV_RDATA: st_d.sw_rdata = st_q.dev_rdata;
                `IRG_H_IRQ_STATUS: st_d.sw_rdata = {5'h00, st_q.irq_status};
                `IRG_H_IRQ_MASK: st_d.sw_rdata = {5'h00, st_q.irq_mask};
                `IRG_H_CFG: st_d.sw_rdata = {7'h00, st_q.one_shot};
                default: st_d.sw_rdata = 8'h00;
            endcase
        end

        // Events set after the clear so a same-cycle event survives
        if (st_q.rd_pend)
        begin
            st_d.dev_rdata = link.reg_rdata;
            st_d.irq_status[`IRG_IRQ_DONE] = 1'b1;
        end
        // Both edges are caught; a trailing extra pulse just adds one more event
        if (st_q.pin_s2 && !st_q.pin_prev)
        begin
            st_d.irq_status[`IRG_IRQ_RISE] = 1'b1;
        end
        if (!st_q.pin_s2 && st_q.pin_prev)
        begin
            st_d.irq_status[`IRG_IRQ_FALL] = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            // Synchroniser starts at the pulled-up idle level, so reset shows no false rising edge
            st_q.pin_s1 <= 1'b1;
            st_q.pin_s2 <= 1'b1;
            st_q.pin_prev <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign link.reg_addr = st_q.reg_addr;
    assign link.reg_wdata = st_q.reg_wdata;
    assign link.reg_wr = st_q.reg_wr;
    assign link.reg_rd = st_q.reg_rd;
    assign sw_rdata = st_q.sw_rdata;
    assign irq = |(st_q.irq_status & st_q.irq_mask);

endmodule : irg_host_ctrl

// *** hdl/irg_sensor_dev.sv ***
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "irg_map.svh"

// Summary of operation
// - Gain field 000 divides object data by eight
// - Gain field resets to 111, register F1h
// - Ambient data never scaled by gain
// - Wide mode disables compensation and detection flags
// - Drive bit selects push-pull or open-drain pin
// - Polarity bit selects active high or low
// - Status bits always read one when set
// - Source field selects none, ready or flags
// - Events from ready or unmasked detection flags
// - Three mask bits gate shock, motion, presence
// - Level mode follows condition every rate cycle
// - Pulse mode repeats pulse while condition holds
// - Host tolerates one spurious trailing pulse
// - Host clears latch bit when flags routed
// - Host avoids flag routing in one-shot, wide
// - Presence tracking preset writes 22h to interrupt control
// - Flags follow their conditions each rate cycle
module irg_sensor_dev #(
    parameter int OBJ_W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Link to host
    irg_link_if.dev_mp link,
    // Sample path
    input wire logic odr_tick,
    input wire logic signed [OBJ_W-1:0] obj_raw,
    input wire logic [15:0] amb_raw,
    input wire logic [2:0] det_cond,
    output logic signed [OBJ_W-1:0] obj_out,
    output logic [15:0] amb_out
);
    import irg_pkg::*;

    generate
        if (OBJ_W <= `IRG_GAIN_SHIFT || OBJ_W > 16)
        begin : g_bad_width
            $error("OBJ_W must lie above the gain shift and at most 16");
        end
    endgenerate

    irg_dev_state_s st_q;
    irg_dev_state_s st_d;

    logic wide_mode;
    logic [2:0] flags_new;
    logic cond_new;
    logic [1:0] src;
    logic src_sig;
    logic pin_level;
    logic signed [OBJ_W-1:0] obj_scaled;

    assign wide_mode = st_q.gain_config[`IRG_GAIN_MSB:`IRG_GAIN_LSB] == `IRG_GAIN_WIDE;
    assign src = st_q.int_ctrl[`IRG_IC_SRC_MSB:`IRG_IC_SRC_LSB];

    // Algorithms are unusable at reduced gain, so their flags stay clear
    assign flags_new = wide_mode ? 3'h0 : det_cond;
    // OR of the enabled flags only
    assign cond_new = |(flags_new & st_q.int_ctrl[`IRG_IC_MSK_MSB:`IRG_IC_MSK_LSB]);

    // Arithmetic shift keeps the sign of the object reading
    assign obj_scaled = wide_mode ? (obj_raw >>> `IRG_GAIN_SHIFT) : obj_raw;

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = 8'h00;

        // Register writes; status registers ignore writes
        if (link.reg_wr)
        begin
            unique case (link.reg_addr)
                `IRG_OFF_GAIN_CONFIG:
                begin
                    st_d.gain_config = link.reg_wdata;
                end
                `IRG_OFF_INT_CTRL:
                begin
                    st_d.int_ctrl = link.reg_wdata;
                end
                `IRG_OFF_ALGORITHM_CONFIG:
                begin
                    st_d.algorithm_config = link.reg_wdata;
                    // Compensation cannot be switched on at reduced gain
                    if (wide_mode)
                    begin
                        st_d.algorithm_config[`IRG_AC_COMP] = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Entering wide mode drops any active compensation
        if (st_d.gain_config[`IRG_GAIN_MSB:`IRG_GAIN_LSB] == `IRG_GAIN_WIDE)
        begin
            st_d.algorithm_config[`IRG_AC_COMP] = 1'b0;
        end

        // Register reads, data valid the next cycle
        if (link.reg_rd)
        begin
            unique case (link.reg_addr)
                `IRG_OFF_GAIN_CONFIG:
                begin
                    st_d.rdata = st_q.gain_config;
                end
                `IRG_OFF_INT_CTRL:
                begin
                    st_d.rdata = st_q.int_ctrl;
                end
                `IRG_OFF_SAMPLE_STATUS:
                begin
                    // Status is active high whatever the pin polarity
                    st_d.rdata[`IRG_SS_SAMPLE_READY_SIGNAL] = st_q.sample_ready_signal;
                    st_d.sample_ready_signal = 1'b0;
                end
                `IRG_OFF_FLAG_STATUS:
                begin
                    st_d.rdata[`IRG_FS_SHOCK] = st_q.flags[0];
                    st_d.rdata[`IRG_FS_MOTION] = st_q.flags[1];
                    st_d.rdata[`IRG_FS_PRESENCE] = st_q.flags[2];
                end
                `IRG_OFF_ALGORITHM_CONFIG:
                begin
                    st_d.rdata = st_q.algorithm_config;
                end
                default:
                begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end

        // Flag combination ends a pulse after one cycle
        if (st_q.algorithm_config[`IRG_AC_PULSED])
        begin
            st_d.int_or = 1'b0;
        end

        // New sample: outputs, flags and combined signal move together
        if (odr_tick)
        begin
            st_d.obj_out = 16'(obj_scaled);
            st_d.amb_out = amb_raw;
            st_d.flags = flags_new;
            // A fresh sample wins over a read that clears it
            st_d.sample_ready_signal = 1'b1;
            // Level mode tracks the condition; pulse mode re-fires while true
            st_d.int_or = cond_new;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
            st_q.gain_config <= `IRG_RST_GAIN_CONFIG;
            st_q.int_ctrl <= `IRG_RST_INT_CTRL;
            st_q.algorithm_config <= `IRG_RST_ALGORITHM_CONFIG;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Pin source; the reserved code releases the pin like code 00
    always_comb
    begin
        unique case (src)
            `IRG_SRC_SAMPLE_READY_SIGNAL:
            begin
                src_sig = st_q.sample_ready_signal;
            end
            `IRG_SRC_OR:
            begin
                src_sig = st_q.int_or;
            end
            default:
            begin
                src_sig = 1'b0;
            end
        endcase
    end

    // Polarity touches the pin only, never the status bits
    assign pin_level = src_sig ^ st_q.int_ctrl[`IRG_IC_POL];

    always_comb
    begin
        if (src != `IRG_SRC_SAMPLE_READY_SIGNAL && src != `IRG_SRC_OR)
        begin
            link.int_oe = 1'b0;
            link.int_out = 1'b0;
        end
        else if (st_q.int_ctrl[`IRG_IC_OD])
        begin
            // Open drain only pulls low; high comes from the pull-up
            link.int_oe = ~pin_level;
            link.int_out = 1'b0;
        end
        else
        begin
            link.int_oe = 1'b1;
            link.int_out = pin_level;
        end
    end

    assign link.reg_rdata = st_q.rdata;
    assign obj_out = OBJ_W'(st_q.obj_out);
    assign amb_out = st_q.amb_out;

endmodule : irg_sensor_dev

// *** pkg/irg_link_if.sv ***
`timescale 1ns/100ps
interface irg_link_if #(parameter logic IDLE_LEVEL = 1'b1);
    import irg_pkg::*;

    // Register port, host to sensor
    irg_byte_t reg_addr;
    irg_byte_t reg_wdata;
    logic reg_wr;
    logic reg_rd;
    irg_byte_t reg_rdata;
    // Interrupt pin
    logic int_out;
    logic int_oe;
    logic int_pin;

    // Released pin settles at the board pull level
    assign int_pin = int_oe ? int_out : IDLE_LEVEL;

    modport dev_mp (
        input reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, int_out, int_oe
    );

    modport host_mp (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input reg_rdata, int_pin
    );
endinterface : irg_link_if

// *** pkg/irg_map.svh ***
`ifndef IRG_MAP_SVH
`define IRG_MAP_SVH

// Sensor register offsets
`define IRG_OFF_GAIN_CONFIG 8'h17
`define IRG_OFF_INT_CTRL 8'h22
`define IRG_OFF_SAMPLE_STATUS 8'h23
`define IRG_OFF_FLAG_STATUS 8'h25
`define IRG_OFF_ALGORITHM_CONFIG 8'h28

// Sensor reset values
`define IRG_RST_GAIN_CONFIG 8'hf1
`define IRG_RST_INT_CTRL 8'h00
`define IRG_RST_ALGORITHM_CONFIG 8'h00

// gain_config fields
`define IRG_GAIN_LSB 4
`define IRG_GAIN_MSB 6
`define IRG_GAIN_WIDE 3'h0
`define IRG_GAIN_SHIFT 3

// interrupt_control fields
`define IRG_IC_POL 7
`define IRG_IC_OD 6
`define IRG_IC_MSK_LSB 3
`define IRG_IC_MSK_MSB 5
`define IRG_IC_LATCH 2
`define IRG_IC_SRC_LSB 0
`define IRG_IC_SRC_MSB 1
`define IRG_SRC_NONE 2'h0
`define IRG_SRC_SAMPLE_READY_SIGNAL 2'h1
`define IRG_SRC_OR 2'h2
`define IRG_PRESET_PRESENCE 8'h22

// sample_status, detection_flag_status, algorithm_config fields
`define IRG_SS_SAMPLE_READY_SIGNAL 2
`define IRG_FS_SHOCK 0
`define IRG_FS_MOTION 1
`define IRG_FS_PRESENCE 2
`define IRG_AC_COMP 2
`define IRG_AC_PULSED 3

// Host controller registers
`define IRG_H_DEV_ADDR 8'h00
`define IRG_H_DEV_WDATA 8'h01
`define IRG_H_CMD 8'h02
`define IRG_H_DEV_RDATA 8'h03
`define IRG_H_IRQ_STATUS 8'h04
`define IRG_H_IRQ_MASK 8'h05
`define IRG_H_CFG 8'h06
`define IRG_CMD_WR 0
`define IRG_CMD_RD 1
`define IRG_CMD_PRESET 2
`define IRG_IRQ_RISE 0
`define IRG_IRQ_FALL 1
`define IRG_IRQ_DONE 2
`define IRG_CFG_ONE_SHOT 0

`endif

// *** pkg/irg_pkg.sv ***
package irg_pkg;

    typedef logic [7:0] irg_byte_t;

    typedef struct packed {
        irg_byte_t gain_config;
        irg_byte_t int_ctrl;
        irg_byte_t algorithm_config;
        logic [2:0] flags;
        logic sample_ready_signal;
        logic int_or;
        irg_byte_t rdata;
        logic [15:0] obj_out;
        logic [15:0] amb_out;
    } irg_dev_state_s;

    typedef struct packed {
        irg_byte_t dev_addr;
        irg_byte_t dev_wdata;
        irg_byte_t dev_rdata;
        irg_byte_t sw_rdata;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic one_shot;
        logic wide_seen;
        irg_byte_t reg_addr;
        irg_byte_t reg_wdata;
        logic reg_wr;
        logic reg_rd;
        logic rd_pend;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
    } irg_host_state_s;

endpackage : irg_pkg

// *** tb/ir_sensor_interrupt_gain_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`include "irg_map.svh"
module ir_sensor_interrupt_gain_ctrl_tb_top;
    import irg_pkg::*;
    logic core_clk;
    logic rst_b;
    irg_byte_t sw_addr;
    irg_byte_t sw_wdata;
    logic sw_wr;
    logic sw_rd;
    irg_byte_t sw_rdata;
    logic irq;
    logic odr_tick;
    logic [15:0] obj_raw;
    logic [15:0] amb_raw;
    logic [2:0] det_cond;
    logic [15:0] obj_out;
    logic [15:0] amb_out;
    irg_byte_t rd;
    int failures;
    int n_checks;
    int cnt;
    irg_link_if #(.IDLE_LEVEL(1'b1)) u_irg_link_if ();
    irg_sensor_dev #(.OBJ_W(16)) u_irg_sensor_dev (.core_clk(core_clk), .rst_b(rst_b), .link(u_irg_link_if),
        .odr_tick(odr_tick), .obj_raw(obj_raw), .amb_raw(amb_raw), .det_cond(det_cond), .obj_out(obj_out),
        .amb_out(amb_out));
    irg_host_ctrl u_irg_host_ctrl (.core_clk(core_clk), .rst_b(rst_b), .link(u_irg_link_if), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
    irg_link_monitor u_irg_link_monitor (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(u_irg_link_if.reg_addr),
        .reg_wdata(u_irg_link_if.reg_wdata), .reg_wr(u_irg_link_if.reg_wr), .reg_rd(u_irg_link_if.reg_rd),
        .reg_rdata(u_irg_link_if.reg_rdata), .int_out(u_irg_link_if.int_out), .int_oe(u_irg_link_if.int_oe));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask : chk_bit
    // Each strobe waits an edge first, so no strobe is assigned twice in one step
    task automatic sw_write(input irg_byte_t a, input irg_byte_t d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input irg_byte_t a, output irg_byte_t d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask : sw_read
    task automatic dev_write(input irg_byte_t a, input irg_byte_t d);
        sw_write(`IRG_H_DEV_ADDR, a);
        sw_write(`IRG_H_DEV_WDATA, d);
        sw_write(`IRG_H_CMD, 8'h01);
        repeat (3) @(posedge core_clk);
    endtask : dev_write
    // The controller has no queue, so each read waits for its done flag
    task automatic dev_chk(input irg_byte_t a, input irg_byte_t m, input irg_byte_t e);
        sw_write(`IRG_H_DEV_ADDR, a);
        sw_write(`IRG_H_CMD, 8'h02);
        rd = 8'h00;
        for (int i = 0; i < 10 && rd[`IRG_IRQ_DONE] !== 1'b1; i++)
            sw_read(`IRG_H_IRQ_STATUS, rd);
        chk_bit(rd[`IRG_IRQ_DONE], 1'b1);
        if (rd[`IRG_IRQ_DONE] !== 1'b1)
            stop_test();
        sw_read(`IRG_H_DEV_RDATA, rd);
        sw_write(`IRG_H_IRQ_STATUS, 8'h04);
        chk_val({8'h00, rd & m}, {8'h00, e});
    endtask : dev_chk
    task automatic pin(input logic p, input logic oe);
        chk_bit(u_irg_link_if.int_pin, p);
        chk_bit(u_irg_link_if.int_oe, oe);
    endtask : pin
    task automatic tick();
        @(posedge core_clk);
        odr_tick <= 1'b1;
        @(posedge core_clk);
        odr_tick <= 1'b0;
    endtask : tick
    task automatic tick_settle();
        tick();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : tick_settle
    initial
    begin
        rst_b = 1'b0;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        odr_tick = 1'b0;
        obj_raw = 16'hfce0;
        amb_raw = 16'h1a2b;
        det_cond = 3'h0;
        failures = 0;
        n_checks = 0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1;
        pin(1'b1, 1'b0);
        // Released pin after reset must not look like an edge to the host
        repeat (4) @(posedge core_clk);
        sw_read(`IRG_H_IRQ_STATUS, rd);
        chk_val({8'h00, rd}, 16'h0000);
        dev_chk(`IRG_OFF_GAIN_CONFIG, 8'hff, 8'hf1);
        dev_chk(`IRG_OFF_INT_CTRL, 8'hff, 8'h00);
        tick_settle();
        chk_val(obj_out, 16'hfce0);
        dev_write(`IRG_OFF_GAIN_CONFIG, 8'h81);
        det_cond <= 3'h7;
        tick_settle();
        chk_val(obj_out, 16'hff9c);
        chk_val(amb_out, 16'h1a2b);
        dev_chk(`IRG_OFF_FLAG_STATUS, 8'h07, 8'h00);
        dev_write(`IRG_OFF_ALGORITHM_CONFIG, 8'h04);
        dev_chk(`IRG_OFF_ALGORITHM_CONFIG, 8'h04, 8'h00);
        dev_write(`IRG_OFF_INT_CTRL, 8'h22);
        dev_chk(`IRG_OFF_INT_CTRL, 8'hff, 8'h20);
        dev_write(`IRG_OFF_GAIN_CONFIG, 8'hf1);
        $display("gain test done");
        dev_write(`IRG_OFF_INT_CTRL, 8'h80);
        det_cond <= 3'h5;
        tick_settle();
        dev_chk(`IRG_OFF_FLAG_STATUS, 8'h07, 8'h05);
        dev_chk(`IRG_OFF_SAMPLE_STATUS, 8'h04, 8'h04);
        dev_chk(`IRG_OFF_SAMPLE_STATUS, 8'h04, 8'h00);
        det_cond <= 3'h0;
        tick_settle();
        dev_chk(`IRG_OFF_FLAG_STATUS, 8'h07, 8'h00);
        $display("flag test done");
        // Ready source under every drive and polarity; released pin pulls high
        for (int k = 0; k < 4; k++)
        begin
            dev_write(`IRG_OFF_INT_CTRL, {k[1], k[0], 6'h01});
            tick_settle();
            pin(~k[1], k[0] ? k[1] : 1'b1);
            dev_chk(`IRG_OFF_SAMPLE_STATUS, 8'h00, 8'h00);
            pin(k[1], k[0] ? ~k[1] : 1'b1);
        end
        dev_write(`IRG_OFF_INT_CTRL, 8'h03);
        tick_settle();
        pin(1'b1, 1'b0);
        $display("pin test done");
        for (int m = 0; m < 8; m++)
        begin
            dev_write(`IRG_OFF_INT_CTRL, {2'b00, 3'(m), 3'b010});
            for (int c = 0; c < 8; c++)
            begin
                det_cond <= 3'(c);
                tick_settle();
                chk_bit(u_irg_link_if.int_pin, |(3'(m) & 3'(c)));
                repeat (4) @(posedge core_clk);
                #1;
                chk_bit(u_irg_link_if.int_pin, |(3'(m) & 3'(c)));
            end
        end
        $display("mask test done");
        dev_write(`IRG_OFF_INT_CTRL, `IRG_PRESET_PRESENCE);
        det_cond <= 3'h0;
        tick_settle();
        sw_write(`IRG_H_IRQ_MASK, 8'h03);
        sw_write(`IRG_H_IRQ_STATUS, 8'h07);
        det_cond <= 3'h4;
        tick_settle();
        tick_settle();
        chk_bit(irq, 1'b1);
        sw_write(`IRG_H_IRQ_STATUS, 8'h01);
        tick_settle();
        chk_bit(irq, 1'b0);
        det_cond <= 3'h0;
        tick_settle();
        tick_settle();
        chk_bit(irq, 1'b1);
        sw_write(`IRG_H_IRQ_MASK, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        chk_bit(irq, 1'b0);
        sw_write(`IRG_H_IRQ_STATUS, 8'h07);
        $display("irq test done");
        dev_write(`IRG_OFF_ALGORITHM_CONFIG, 8'h08);
        det_cond <= 3'h4;
        for (int t = 0; t < 3; t++)
        begin
            if (t == 2)
                det_cond <= 3'h0;
            tick();
            cnt = 0;
            repeat (6)
            begin
                #1;
                cnt += int'(u_irg_link_if.int_pin === 1'b1);
                @(posedge core_clk);
            end
            if (t < 2)
                chk_bit(cnt == 1, 1'b1);
        end
        // A trailing pulse after the flags drop is tolerated
        chk_bit(cnt <= 1, 1'b1);
        dev_write(`IRG_OFF_ALGORITHM_CONFIG, 8'h00);
        $display("pulse test done");
        dev_write(`IRG_OFF_INT_CTRL, 8'h26);
        dev_chk(`IRG_OFF_INT_CTRL, 8'hff, 8'h22);
        sw_write(`IRG_H_CFG, 8'h01);
        sw_write(`IRG_H_CMD, 8'h04);
        repeat (3) @(posedge core_clk);
        dev_chk(`IRG_OFF_INT_CTRL, 8'hff, 8'h20);
        sw_write(`IRG_H_CFG, 8'h00);
        sw_write(`IRG_H_CMD, 8'h04);
        repeat (3) @(posedge core_clk);
        dev_chk(`IRG_OFF_INT_CTRL, 8'hff, 8'h22);
        dev_chk(8'h30, 8'hff, 8'h00);
        sw_read(8'h07, rd);
        chk_val({8'h00, rd}, 16'h0000);
        $display("guard test done");
        stop_test();
    end
endmodule : ir_sensor_interrupt_gain_ctrl_tb_top

// *** tb/irg_link_monitor.sv ***
`timescale 1ns/100ps
`include "irg_map.svh"
module irg_link_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire irg_pkg::irg_byte_t reg_addr,
    input wire irg_pkg::irg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire irg_pkg::irg_byte_t reg_rdata,
    // Interrupt pin
    input wire logic int_out,
    input wire logic int_oe
);
    import irg_pkg::*;
    irg_byte_t gain_q;
    irg_byte_t ctrl_q;
    logic pulsed_q;
    logic drives;
    logic sig;
    // Shadows follow link writes, so they change on the same edge as the sensor
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gain_q <= `IRG_RST_GAIN_CONFIG;
            ctrl_q <= `IRG_RST_INT_CTRL;
            pulsed_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `IRG_OFF_GAIN_CONFIG)
                gain_q <= reg_wdata;
            if (reg_addr == `IRG_OFF_INT_CTRL)
                ctrl_q <= reg_wdata;
            if (reg_addr == `IRG_OFF_ALGORITHM_CONFIG)
                pulsed_q <= reg_wdata[`IRG_AC_PULSED];
        end
    end
    // Sources 01 and 10 drive the pin; 00 and 11 release it
    assign drives = ctrl_q[1] ^ ctrl_q[0];
    // Open-drain shows the signal through the enable only
    assign sig = (ctrl_q[`IRG_IC_OD] ? ~int_oe : int_out) ^ ctrl_q[`IRG_IC_POL];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_ctrl_wr;
        reg_wr && reg_addr == `IRG_OFF_INT_CTRL;
    endsequence
    sequence s_pulse;
        drives && ctrl_q[1] && pulsed_q && sig;
    endsequence
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle");
    property p_gain_rb;
        reg_rd && reg_addr == `IRG_OFF_GAIN_CONFIG |=> reg_rdata == gain_q;
    endproperty
    a_gain_rb: assert property (p_gain_rb)
        else $error("gain readback wrong");
    property p_pin_off;
        !drives |-> !int_oe;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin driven while released");
    property p_pp_drive;
        drives && !ctrl_q[`IRG_IC_OD] |-> int_oe;
    endproperty
    a_pp_drive: assert property (p_pp_drive)
        else $error("push-pull pin not driven");
    property p_od_low;
        drives && ctrl_q[`IRG_IC_OD] |-> !int_out;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain drives high");
    property p_pulse_once;
        s_pulse |=> !sig;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("pulse longer than one cycle");
    property p_latch_clr;
        s_ctrl_wr ##0 reg_wdata[1:0] == `IRG_SRC_OR |-> !reg_wdata[`IRG_IC_LATCH];
    endproperty
    a_latch_clr: assert property (p_latch_clr)
        else $error("latch set with flag routing");
    property p_wide_src;
        s_ctrl_wr ##0 gain_q[`IRG_GAIN_MSB:`IRG_GAIN_LSB] == `IRG_GAIN_WIDE |-> reg_wdata[1:0] != `IRG_SRC_OR;
    endproperty
    a_wide_src: assert property (p_wide_src)
        else $error("flag routing in wide mode");
endmodule : irg_link_monitor
